// [hw/dpb_map.svh]
// Build-time configuration constants for the DDR3 PHY build-options block
`ifndef DPB_MAP_SVH
`define DPB_MAP_SVH
// ****************************************
// Memory clock range, MHz
// ****************************************
`define DPB_MCLK_MIN_MHZ        16'd300
`define DPB_MCLK_MAX_MHZ        16'd400
`define DPB_MCLK_DEF_MHZ        16'd400
`define DPB_REF_RATIO           16'd4
// ****************************************
// Build options (fixed at generation)
// ****************************************
`define DPB_MEM_TYPE            2'd0
`define DPB_DEV_WIDTH           5'd8
`define DPB_BUS_WIDTH           8'd32
`define DPB_RANKS               2'd1
`define DPB_ADDR_MIRROR         1'b0
`define DPB_CLK_PER_RANK        2'd1
`define DPB_CKE_PER_RANK        2'd1
`define DPB_TWO_T               1'b0
`define DPB_WRLVL_ON            1'b1
`define DPB_RST_TO_MEM          1'b1
// ****************************************
// Mode register defaults
// ****************************************
`define DPB_BL_DEF              2'd0
`define DPB_CL_DEF              4'd5
`define DPB_CL_MIN              4'd5
`define DPB_CL_MAX              4'd8
// Maximum ranks and lanes
`define DPB_MAX_RANKS           2
`define DPB_MAX_BUS             72
`endif

// [hw/dpb_pkg.sv]
// Types for the DDR3 PHY build-options block
package dpb_pkg;
  // Memory type
  typedef enum logic [1:0] {
    DPB_UDIMM,
    DPB_RDIMM,
    DPB_ONBOARD
  } dpb_mem_t;
  // Burst length choices
  typedef enum logic [1:0] {
    DPB_BL_FIXED8,
    DPB_BL_OTF,
    DPB_BL_FIXED4
  } dpb_bl_t;
  // Reset sequencer states
  typedef enum logic [1:0] {
    DPB_RS_HOLD,
    DPB_RS_WAIT,
    DPB_RS_RUN
  } dpb_rst_st_t;
endpackage

// [hw/dpb_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/10ps
module dpb_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Level
  input  wire logic d_in,
  output logic      q_out
);
  // ****************************************
  // Two stages
  // ****************************************
  logic meta_q;               // First stage, read only by the second
  logic sync_q;               // Second stage
  // Both stages on every rising edge
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule // dpb_sync

// [hw/dpb_top.sv]
// DDR3 PHY build options: static configuration and memory-side reset and clock fan-out
`timescale 1ns/10ps
`include "dpb_map.svh"
module dpb_top #(
  // Build-time choices; regenerate to change
  parameter logic [15:0] MCLK_MHZ      = `DPB_MCLK_DEF_MHZ,
  parameter logic [1:0]  MEM_TYPE      = `DPB_MEM_TYPE,
  parameter logic [4:0]  DEV_WIDTH     = `DPB_DEV_WIDTH,
  parameter logic [7:0]  BUS_WIDTH     = `DPB_BUS_WIDTH,
  parameter logic [1:0]  RANKS         = `DPB_RANKS,
  parameter logic        ADDR_MIRROR   = `DPB_ADDR_MIRROR,
  parameter logic [1:0]  CLK_PER_RANK  = `DPB_CLK_PER_RANK,
  parameter logic [1:0]  CKE_PER_RANK  = `DPB_CKE_PER_RANK,
  parameter logic        TWO_T         = `DPB_TWO_T,
  parameter logic        WRLVL_ON      = `DPB_WRLVL_ON,
  parameter logic        RST_TO_MEM    = `DPB_RST_TO_MEM,
  parameter logic [1:0]  BL_INIT       = `DPB_BL_DEF,
  parameter logic [3:0]  CL_INIT       = `DPB_CL_DEF
) (
  // System clock and core reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      rstn_in,
  // Memory clock domain (link)
  input  wire logic                      mem_clk_in,
  // Controller side requests
  input  wire logic [`DPB_MAX_RANKS-1:0] cke_req_in,
  input  wire logic [15:0]               addr_in,
  input  wire logic [2:0]                bank_in,
  input  wire logic [`DPB_MAX_RANKS-1:0] cs_sel_in,
  input  wire logic [`DPB_MAX_BUS-1:0]   wdata_in,
  // Memory side
  output logic [2*`DPB_MAX_RANKS-1:0]    memory_clock_out,
  output logic [2*`DPB_MAX_RANKS-1:0]    cke_out,
  output logic                           mem_rst_n_out,
  output logic [15:0]                    rank_addr_out,
  output logic [2:0]                     rank_bank_out,
  output logic [`DPB_MAX_BUS-1:0]        lane_data_out,
  output logic [`DPB_MAX_BUS-1:0]        lane_en_out,
  // Status of the fixed configuration
  output logic                           cfg_ok_out,
  output logic                           two_t_out,
  output logic                           wrlvl_on_out,
  output logic [1:0]                     bl_init_out,
  output logic [3:0]                     cl_init_out,
  output logic                           ref_ratio4_out
);
  // ****************************************
  // Static legality of build options
  // ****************************************
  localparam logic MEM_DIMM = (MEM_TYPE != 2'(dpb_pkg::DPB_ONBOARD));
  localparam logic MCLK_OK  = (MCLK_MHZ >= `DPB_MCLK_MIN_MHZ)
                           && (MCLK_MHZ <= `DPB_MCLK_MAX_MHZ);
  localparam logic DEV_OK   = (DEV_WIDTH == 5'd4) || (DEV_WIDTH == 5'd8)
                           || (DEV_WIDTH == 5'd16);
  localparam logic RANK_OK  = (RANKS >= 2'd1) && (RANKS <= 2'd2);
  localparam logic CLKW_OK  = (CLK_PER_RANK == 2'd1) || (CLK_PER_RANK == 2'd2);
  localparam logic CKEW_OK  = (CKE_PER_RANK == 2'd1) || (CKE_PER_RANK == 2'd2);
  localparam logic BUS_OK   = (BUS_WIDTH != 8'd0) && (BUS_WIDTH <= 8'(`DPB_MAX_BUS));
  localparam logic BL_OK    = (BL_INIT <= 2'd2);
  localparam logic CL_OK    = (CL_INIT >= `DPB_CL_MIN) && (CL_INIT <= `DPB_CL_MAX);
  // Effective options after forcing
  // Options that the memory type rules out fall back to the safe value
  localparam logic MIRROR_EFF = ADDR_MIRROR && MEM_DIMM && (RANKS == 2'd2);
  localparam logic TWO_T_EFF  = TWO_T && (MEM_TYPE != 2'(dpb_pkg::DPB_RDIMM));
  localparam logic WRLVL_EFF  = WRLVL_ON || MEM_DIMM;
  localparam logic CFG_OK = MCLK_OK && DEV_OK && RANK_OK && CLKW_OK && CKEW_OK
                         && BUS_OK && BL_OK && CL_OK;

  // ****************************************
  // State and its next value
  // ****************************************
  typedef struct packed {
    dpb_pkg::dpb_rst_st_t     st;     // Reset sequencer
    logic                     mrst_n; // Memory reset request, system domain
    logic [15:0]              addr;   // Registered rank address
    logic [2:0]               bank;   // Registered bank
    logic [`DPB_MAX_BUS-1:0]  data;   // Registered lane data
    logic                     tick;   // 2T alternate slot
  } dpb_state_t;
  dpb_state_t s_q;
  dpb_state_t s_d;

  // Lane mask from the chosen bus width
  logic [`DPB_MAX_BUS-1:0] lane_mask;
  always_comb begin
    for (int i = 0; i < `DPB_MAX_BUS; i++) begin
      lane_mask[i] = (i < int'(BUS_WIDTH));
    end
  end

  // Mirror swap for the second rank (A3/A4, A5/A6, A7/A8, BA0/BA1)
  function automatic logic [18:0] dpb_mirror(input logic [15:0] a, input logic [2:0] b);
    logic [15:0] ma;
    logic [2:0]  mb;
    ma = a;
    mb = b;
    ma[3] = a[4];
    ma[4] = a[3];
    ma[5] = a[6];
    ma[6] = a[5];
    ma[7] = a[8];
    ma[8] = a[7];
    mb[0] = b[1];
    mb[1] = b[0];
    return {ma, mb};
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    // Core reset releases memory reset two steps later
    // Sequencer stays in RUN until the core reset returns
    unique case (s_q.st)
      dpb_pkg::DPB_RS_HOLD: begin
        s_d.mrst_n = 1'b0;
        s_d.st     = dpb_pkg::DPB_RS_WAIT;
      end
      dpb_pkg::DPB_RS_WAIT: begin
        s_d.mrst_n = 1'b1;
        s_d.st     = dpb_pkg::DPB_RS_RUN;
      end
      dpb_pkg::DPB_RS_RUN: begin
        s_d.mrst_n = 1'b1;
      end
    endcase
    // Address: mirror only the second rank
    if (MIRROR_EFF && cs_sel_in[1]) begin
      {s_d.addr, s_d.bank} = dpb_mirror(addr_in, bank_in);
    end else begin
      s_d.addr = addr_in;
      s_d.bank = bank_in;
    end
    // Unused lanes parked low
    s_d.data = wdata_in & lane_mask;
    // 2T: command held over two cycles
    s_d.tick = TWO_T_EFF ? ~s_q.tick : 1'b0;
    if (TWO_T_EFF && s_q.tick) begin
      s_d.addr = s_q.addr;
      s_d.bank = s_q.bank;
    end
  end

  // ****************************************
  // State register, synchronous reset
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s_q.st     <= dpb_pkg::DPB_RS_HOLD;
      s_q.mrst_n <= 1'b0;
      s_q.addr   <= 16'h0000;
      s_q.bank   <= 3'h0;
      s_q.data   <= '0;
      s_q.tick   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Memory clock domain
  // ****************************************
  // Reset request crosses as a level
  // Its own reset is the request itself, taken on a memory clock edge, so assertion is synchronised as well as release
  logic mrst_n_sync;
  dpb_sync #(
    .RST_VAL (1'b0)
  ) u_mrst_sync (
    .clk_in  (mem_clk_in),
    .rstn_in (s_q.mrst_n),
    .d_in    (s_q.mrst_n),
    .q_out   (mrst_n_sync)
  );
  // CKE requests cross as levels, one synchroniser per rank
  // Reset from the synchronised request, so its release never races the edge
  logic [`DPB_MAX_RANKS-1:0] cke_sync;
  for (genvar r = 0; r < `DPB_MAX_RANKS; r++) begin : g_cke
    dpb_sync #(
      .RST_VAL (1'b0)
    ) u_cke_sync (
      .clk_in  (mem_clk_in),
      .rstn_in (mrst_n_sync),
      .d_in    (cke_req_in[r]),
      .q_out   (cke_sync[r])
    );
  end

  // Clock and clock-enable fan-out per rank
  always_comb begin
    for (int r = 0; r < `DPB_MAX_RANKS; r++) begin
      for (int k = 0; k < 2; k++) begin
        // Gated copy of the memory clock; idle low when unused
        memory_clock_out[2*r+k] = (r < int'(RANKS)) && (k < int'(CLK_PER_RANK))
                                  && mrst_n_sync && mem_clk_in;
        cke_out[2*r+k]          = (r < int'(RANKS)) && (k < int'(CKE_PER_RANK))
                                  && cke_sync[r];
      end
    end
  end

  // Memory reset: follows core reset only when the option is built in
  // Asserts at once with the request, since the memory clock may be stopped
  assign mem_rst_n_out = RST_TO_MEM ? (mrst_n_sync & s_q.mrst_n) : 1'b1;
  assign rank_addr_out = s_q.addr;
  assign rank_bank_out = s_q.bank;
  assign lane_data_out = s_q.data;
  assign lane_en_out   = lane_mask;
  // Fixed configuration reported for the controller
  assign cfg_ok_out     = CFG_OK;
  assign two_t_out      = TWO_T_EFF;
  assign wrlvl_on_out   = WRLVL_EFF;
  assign bl_init_out    = BL_INIT;
  assign cl_init_out    = CL_INIT;
  assign ref_ratio4_out = 1'b1;

  // ****************************************
  // Checks
  // ****************************************
  // Core reset seen high after being low
  sequence s_rst_rel;
    $rose(rstn_in);
  endsequence
  // Request and memory reset both steady over three memory clock edges
  sequence s_cke_req_hi;
    (mrst_n_sync && cke_req_in[0] && (RANKS != 2'd0)) [*3];
  endsequence
  sequence s_cke_req_lo;
    (mrst_n_sync && !cke_req_in[0]) [*3];
  endsequence
  // Request stays low through every core reset cycle
  property p_mrst_hold;
    @(posedge sys_clk_in) !rstn_in |=> !s_q.mrst_n;
  endproperty
  a_mrst_hold: assert property (p_mrst_hold) else $error("memory reset not held");
  // Request lifts two edges after the release: WAIT first, then RUN
  property p_mrst_rel;
    @(posedge sys_clk_in) disable iff (!rstn_in) s_rst_rel |-> ##2 s_q.mrst_n;
  endproperty
  a_mrst_rel: assert property (p_mrst_rel) else $error("memory reset not released");
  // Pin low at once while the request is low, memory clock running or not
  property p_mem_rst_low;
    @(posedge sys_clk_in) (RST_TO_MEM && !s_q.mrst_n) |-> !mem_rst_n_out;
  endproperty
  a_mem_rst_low: assert property (p_mem_rst_low) else $error("memory reset not asserted");
  // Lanes above the built width never carry data
  property p_lanes;
    @(posedge sys_clk_in) disable iff (!rstn_in) ((lane_data_out & ~lane_mask) == '0);
  endproperty
  a_lanes: assert property (p_lanes) else $error("unused lane driven");
  // Odd 2T slot repeats the address of the even one
  property p_two_t;
    @(posedge sys_clk_in) disable iff (!rstn_in) (TWO_T_EFF && s_q.tick) |=> $stable(s_q.addr);
  endproperty
  a_two_t: assert property (p_two_t) else $error("2T address changed");
  // First rank never sees a swapped address
  property p_mirror;
    @(posedge sys_clk_in) disable iff (!rstn_in) (!cs_sel_in[1] && !s_q.tick) |=> (s_q.addr == $past(addr_in));
  endproperty
  a_mirror: assert property (p_mirror) else $error("rank0 address altered");
  // DIMM builds cannot turn write leveling off
  property p_wrlvl;
    @(posedge sys_clk_in) MEM_DIMM |-> wrlvl_on_out;
  endproperty
  a_wrlvl: assert property (p_wrlvl) else $error("write leveling off on DIMM");
  // Synchroniser passes a core reset on to the pin
  property p_mem_rst;
    @(posedge mem_clk_in) (RST_TO_MEM && !s_q.mrst_n) |=> ##1 !mem_rst_n_out;
  endproperty
  a_mem_rst: assert property (p_mem_rst) else $error("memory reset not passed");
  // Steady clock-enable request reaches the pin within three memory clocks
  property p_cke_on;
    @(posedge mem_clk_in) s_cke_req_hi |=> cke_out[0];
  endproperty
  a_cke_on: assert property (p_cke_on) else $error("clock enable not raised");
  property p_cke_off;
    @(posedge mem_clk_in) s_cke_req_lo |=> !cke_out[0];
  endproperty
  a_cke_off: assert property (p_cke_off) else $error("clock enable not dropped");
  // Slots above the built rank count stay low
  property p_rank_slots;
    @(posedge sys_clk_in) (RANKS == 2'd1) |-> (memory_clock_out[3:2] == 2'b00) && (cke_out[3:2] == 2'b00);
  endproperty
  a_rank_slots: assert property (p_rank_slots) else $error("unbuilt rank driven");
  // Second clock slot of each rank stays low in a one-clock build
  property p_clk_slots;
    @(posedge sys_clk_in) (CLK_PER_RANK == 2'd1) |-> !memory_clock_out[1] && !memory_clock_out[3];
  endproperty
  a_clk_slots: assert property (p_clk_slots) else $error("unbuilt clock driven");
  // Built latency lies in the legal range
  property p_cfg;
    @(posedge sys_clk_in) cfg_ok_out |-> (cl_init_out >= 4'd5 && cl_init_out <= 4'd8);
  endproperty
  a_cfg: assert property (p_cfg) else $error("latency out of range");
endmodule // dpb_top

// [testbench/dpb_mem_model.sv]
// Behavioural model of the memory devices on the far side of the PHY
`timescale 1ns/10ps
module dpb_mem_model (
  // Memory clock, clock enable and reset from the PHY
  input  wire logic        mem_ck_in,
  input  wire logic        cke_in,
  input  wire logic        mem_rstn_in,
  // Clock edges taken while enabled
  output logic [15:0]      act_edges_out
);
  // ****************************************
  // Device state
  // ****************************************
  // Reset wipes the device; an edge counts only with clock enable high
  always @(posedge mem_ck_in or negedge mem_rstn_in) begin
    if (!mem_rstn_in) begin
      act_edges_out <= 16'h0;
    end else if (cke_in) begin
      act_edges_out <= act_edges_out + 16'h1;
    end
  end
endmodule // dpb_mem_model

// [testbench/dpb_top_bench.sv]
// Self-checking bench for the DDR3 PHY build-options block
`timescale 1ns/10ps
`include "dpb_map.svh"
module dpb_top_bench;
  // ****************************************
  // Signals and notes
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [2:0]  bank;
    logic [71:0] data;
  } dpb_exp_t;                              // One data-path note
  logic        sys_clk_in = 1'b0;
  logic        mem_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [1:0]  cke_req_in = 2'h0;
  logic [15:0] addr_in    = 16'h0;
  logic [2:0]  bank_in    = 3'h0;
  logic [1:0]  cs_sel_in  = 2'h0;
  logic [71:0] wdata_in   = 72'h0;
  logic        vld        = 1'b0;           // Note launched this cycle
  logic        vld_p      = 1'b0;           // Note ripe at the outputs
  logic [31:0] seed       = 32'h000182cf;   // Fixed start of the sequence
  logic [71:0] lane_mask  = (72'h1 << `DPB_BUS_WIDTH) - 72'h1;
  logic [3:0]  memory_clock_out, cke_out;
  logic        mem_rst_n_out, cfg_ok_out, two_t_out, wrlvl_on_out, ref_ratio4_out;
  logic [15:0] rank_addr_out, act_edges, c0;
  logic [2:0]  rank_bank_out;
  logic [71:0] lane_data_out, lane_en_out;
  logic [1:0]  bl_init_out;
  logic [3:0]  cl_init_out;
  int          n_fail = 0;
  int          n_tests = 0;
  dpb_exp_t    q[$];                        // Expected data-path results
  // Clocks: the memory clock rising edges never line up with the system edges
  always #2 sys_clk_in = ~sys_clk_in;
  always #62.5 mem_clk_in = ~mem_clk_in;
  dpb_top dpb_top_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .mem_clk_in(mem_clk_in),
    .cke_req_in(cke_req_in), .addr_in(addr_in), .bank_in(bank_in), .cs_sel_in(cs_sel_in),
    .wdata_in(wdata_in), .memory_clock_out(memory_clock_out), .cke_out(cke_out),
    .mem_rst_n_out(mem_rst_n_out), .rank_addr_out(rank_addr_out), .rank_bank_out(rank_bank_out),
    .lane_data_out(lane_data_out), .lane_en_out(lane_en_out), .cfg_ok_out(cfg_ok_out),
    .two_t_out(two_t_out), .wrlvl_on_out(wrlvl_on_out), .bl_init_out(bl_init_out),
    .cl_init_out(cl_init_out), .ref_ratio4_out(ref_ratio4_out));
  dpb_mem_model dpb_mem_model_i (.mem_ck_in(memory_clock_out[0]), .cke_in(cke_out[0]),
    .mem_rstn_in(mem_rst_n_out), .act_edges_out(act_edges));
  // ****************************************
  // Helpers
  // ****************************************
  // Xorshift step; updates the shared seed
  function automatic logic [31:0] next_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Case-equal compare; an unknown never matches
  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Fixed build options; called twice since they must not move
  task automatic chk_static();
    chk("cfg_ok", 72'h1, 72'(cfg_ok_out));
    chk("two_t", 72'h0, 72'(two_t_out));
    chk("wrlvl_on", 72'h1, 72'(wrlvl_on_out));
    chk("bl_init", 72'h0, 72'(bl_init_out));
    chk("cl_init", 72'h5, 72'(cl_init_out));
    chk("ref_ratio4", 72'h1, 72'(ref_ratio4_out));
    chk("lane_en", lane_mask, lane_en_out);
  endtask
  // Reset release, then memory reset must lift within the sync path
  task automatic release_rst();
    @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    repeat (3) @(posedge mem_clk_in);
    #1;
    chk("mem_rst_n", 72'h1, 72'(mem_rst_n_out));
  endtask
  // Clock enable request, then count enabled edges at the memory
  task automatic cke_step(input logic [1:0] req, input logic [3:0] exp_cke, input logic [15:0] exp_n);
    @(posedge sys_clk_in);
    cke_req_in <= req;
    repeat (4) @(posedge mem_clk_in);
    #1;
    chk("cke", 72'(exp_cke), 72'(cke_out));
    c0 = act_edges;
    repeat (4) @(posedge mem_clk_in);
    #1;
    chk("mem_edges", 72'(exp_n), 72'(act_edges - c0));
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge sys_clk_in) vld_p <= vld;
  // Oldest note against what the outputs show half a cycle later
  always @(negedge sys_clk_in) begin
    dpb_exp_t n;
    if (vld_p && q.size() > 0) begin
      n = q.pop_front();
      chk("rank_addr", 72'(n.addr), 72'(rank_addr_out));
      chk("rank_bank", 72'(n.bank), 72'(rank_bank_out));
      chk("lane_data", n.data, lane_data_out);
    end
  end
  // Watchdog: whole run needs about 5 us
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r0, r1, r2;
    dpb_exp_t    e;
    repeat (10) @(posedge sys_clk_in);
    chk("mem_rst_n", 72'h0, 72'(mem_rst_n_out));
    release_rst();
    chk_static();
    // Back-to-back random traffic; mirror is off, so rank 1 passes unchanged
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk_in);
      r0 = next_rnd();
      r1 = next_rnd();
      r2 = next_rnd();
      addr_in <= r0[15:0];
      bank_in <= r0[18:16];
      cs_sel_in <= r0[20:19];
      wdata_in <= {r0[31:24], r1, r2};
      vld <= 1'b1;
      e = {r0[15:0], r0[18:16], {r0[31:24], r1, r2} & lane_mask};
      q.push_back(e);
    end
    @(posedge sys_clk_in);
    vld <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk("notes_left", 72'h0, 72'(q.size()));
    // Memory clock follows the link clock on rank 0 only
    @(posedge mem_clk_in);
    #1;
    chk("mem_clk_hi", 72'h1, 72'(memory_clock_out));
    @(negedge mem_clk_in);
    #1;
    chk("mem_clk_lo", 72'h0, 72'(memory_clock_out));
    cke_step(2'h3, 4'h1, 16'h4);
    cke_step(2'h0, 4'h0, 16'h0);
    cke_step(2'h1, 4'h1, 16'h4);
    // Second reset in mid-run reaches the memory too
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge mem_clk_in);
    #1;
    chk("mem_rst_n", 72'h0, 72'(mem_rst_n_out));
    chk("mem_edges", 72'h0, 72'(act_edges));
    chk("rank_addr", 72'h0, 72'(rank_addr_out));
    release_rst();
    chk_static();
    stop_test();
  end
endmodule // dpb_top_bench
